// [shared/epd_port_defines.vh]
`ifndef EPD_PORT_DEFINES_VH
`define EPD_PORT_DEFINES_VH

// ==========================================================================
// Synchroniser lane positions.
`define SYNC_W            8
`define SYNC_SCLK         0
`define SYNC_SDA          1
`define SYNC_CS_N         2
`define SYNC_DC           3
`define SYNC_RESET_N      4
`define SYNC_MODE         5
`define SYNC_MASTER       6
`define SYNC_CASCADE_CLK  7
// Idle levels: chip select and reset high, the rest low.
`define SYNC_RESET_VAL    8'h0_014

// ==========================================================================
// Frame lengths, as the last bit index of a frame.
`define LAST_BIT_4WIRE    4'h0_007
`define LAST_BIT_3WIRE    4'h0_008
`define BIT_CNT_W         4

// ==========================================================================
// Commands that may be read back.
`define RD_CMD_A          8'h0_01B
`define RD_CMD_B          8'h0_027
`define RD_CMD_C          8'h0_02D
`define RD_CMD_D          8'h0_02E
`define RD_CMD_E          8'h0_02F
`define RD_CMD_F          8'h0_035
// Commands whose data go to the image planes.
`define WR_RAM_BW_CMD     8'h0_024
`define WR_RAM_RED_CMD    8'h0_026

// ==========================================================================
// Image plane geometry: 160 x 296 bits, eight pixels to a byte.
`define RAM_COLS          160
`define RAM_ROWS          296
`define RAM_DEPTH         5920
`define RAM_ADDR_W        13
`define RAM_LAST_ADDR     13'h0_171F

// ==========================================================================
// Reset values.
`define CMD_RESET_VAL     8'h0_000
`define ADDR_RESET_VAL    13'h0_000

`endif

// [rtl/image_ram.v]
`timescale 1ns/1ps
`default_nettype none
`include "epd_port_defines.vh"

// ==========================================================================
// Two image planes, black/white and red, one byte per entry.
module image_ram (
    // Clock.
    input  wire                     clk_i,
    // Write side from the serial port.
    input  wire                     we_i,
    input  wire                     plane_red_i,
    input  wire [`RAM_ADDR_W-1:0]   waddr_i,
    input  wire [7:0]               wdata_i,
    // Read side for the display engine.
    input  wire [`RAM_ADDR_W-1:0]   raddr_i,
    output reg  [7:0]               rdata_bw_o,
    output reg  [7:0]               rdata_red_o
);

    reg [7:0] mem_bw  [0:`RAM_DEPTH-1];
    reg [7:0] mem_red [0:`RAM_DEPTH-1];

    // ======================================================================
    // Write one plane per byte; both planes are read every cycle.
    always @(posedge clk_i) begin
        if (we_i && !plane_red_i) begin
            mem_bw[waddr_i] <= wdata_i;
        end
        if (we_i && plane_red_i) begin
            mem_red[waddr_i] <= wdata_i;
        end
        rdata_bw_o  <= mem_bw[raddr_i];
        rdata_red_o <= mem_red[raddr_i];
    end

endmodule // image_ram

`default_nettype wire

// [rtl/epd_host_serial_port.v]
// Behaviour
// - Strap low selects 4-wire serial mode, strap high selects 3-wire 9-bit mode.
// - 4-wire: data sampled on rising serial clock into 8-bit register, MSB first.
// - A finished byte goes to command register or data destination per its flag.
// - 3-wire: 9-bit frames on rising clock, flag first then eight bits MSB first.
// - 3-wire: flag 0 means command, flag 1 means data.
// - Read-back only for commands 0x1B, 0x27, 0x2D, 0x2E, 0x2F and 0x35.
// - Read byte: MSB first, bits driven on falling clock edges; in 4-wire mode D7 is driven before the first rising edge.
// - Device held in reset while the reset pin is low.
// - Busy high during waveform output, OTP programming or sensor traffic.
// - Slave disables its oscillator, booster and regulator.
// - Two image planes, black/white and red, each 160x296 bits.
`timescale 1ns/1ps
`default_nettype none
`include "epd_port_defines.vh"

module epd_host_serial_port (
    // Clock and reset.
    input  wire                     clk_i,
    input  wire                     rst_i,
    // Serial link pins.
    input  wire                     sclk_i,
    input  wire                     sda_i,
    output reg                      sda_o,
    output reg                      sda_oe_o,
    input  wire                     cs_n_i,
    input  wire                     dc_i,
    input  wire                     reset_in_n_i,
    // Straps.
    input  wire                     serial_mode_strap_i,
    input  wire                     cascade_master_strap_i,
    // Shared cascade clock pin.
    input  wire                     cascade_clock_pin_i,
    output reg                      cascade_clock_pin_o,
    output reg                      cascade_clock_pin_oe_o,
    output reg                      ref_clock_o,
    // Analog block enables.
    output reg                      oscillator_en_o,
    output reg                      booster_en_o,
    output reg                      regulator_en_o,
    // Busy sources and busy pin.
    input  wire                     waveform_active_i,
    input  wire                     otp_program_active_i,
    input  wire                     temp_sensor_active_i,
    output reg                      busy_o,
    // Command and parameter stream to the core.
    output reg                      cmd_strobe_o,
    output reg  [7:0]               cmd_byte_o,
    output reg                      param_strobe_o,
    output reg  [7:0]               param_byte_o,
    // Read-back data from the core.
    input  wire [7:0]               readback_data_i,
    output reg                      read_strobe_o,
    // Display-side read of the image planes.
    input  wire [`RAM_ADDR_W-1:0]   disp_addr_i,
    output wire [7:0]               disp_bw_o,
    output wire [7:0]               disp_red_o
);

    // ======================================================================
    // Input synchronisers: every pin crosses two flip-flops first.
    // They run through reset on purpose, so the straps captured during reset
    // are the real pin levels and not a reset constant.
    wire [`SYNC_W-1:0] pins_raw;
    reg  [`SYNC_W-1:0] meta_ff;
    reg  [`SYNC_W-1:0] sync_ff;
    reg                sclk_d_ff;

    assign pins_raw = {cascade_clock_pin_i, cascade_master_strap_i, serial_mode_strap_i,
                       reset_in_n_i, dc_i, cs_n_i, sda_i, sclk_i};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
            always @(posedge clk_i) begin
                meta_ff[gi] <= pins_raw[gi];
                sync_ff[gi] <= meta_ff[gi];
            end
        end
    endgenerate

    // Internal reset: system reset or the active-low reset pin.
    wire core_rst;
    assign core_rst = rst_i | ~sync_ff[`SYNC_RESET_N];

    wire sclk_s;
    wire sda_s;
    wire cs_n_s;
    wire dc_s;
    wire sclk_rise;
    wire sclk_fall;

    assign sclk_s    = sync_ff[`SYNC_SCLK];
    assign sda_s     = sync_ff[`SYNC_SDA];
    assign cs_n_s    = sync_ff[`SYNC_CS_N];
    assign dc_s      = sync_ff[`SYNC_DC];
    assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s;

    // ======================================================================
    // Straps are followed while in reset and frozen after its release.
    reg three_wire_ff;
    reg master_ff;

    always @(posedge clk_i) begin
        if (core_rst) begin
            three_wire_ff <= sync_ff[`SYNC_MODE];
            master_ff     <= sync_ff[`SYNC_MASTER];
        end
    end

    // ======================================================================
    // Frame receiver. Chip select high clears any partial frame.
    reg [`BIT_CNT_W-1:0] bit_cnt_ff;
    reg [7:0]            shift_ff;
    reg                  flag_ff;
    reg                  done_ff;
    reg [7:0]            byte_ff;
    reg                  byte_is_data_ff;
    wire [`BIT_CNT_W-1:0] last_bit;

    assign last_bit = three_wire_ff ? `LAST_BIT_3WIRE : `LAST_BIT_4WIRE;

    always @(posedge clk_i) begin
        if (core_rst) begin
            sclk_d_ff       <= 1'b0;
            bit_cnt_ff      <= {`BIT_CNT_W{1'b0}};
            shift_ff        <= 8'h0_000;
            flag_ff         <= 1'b0;
            done_ff         <= 1'b0;
            byte_ff         <= 8'h0_000;
            byte_is_data_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            done_ff   <= 1'b0;
            if (cs_n_s) begin
                bit_cnt_ff <= {`BIT_CNT_W{1'b0}};
            end else if (sclk_rise) begin
                if (three_wire_ff && bit_cnt_ff == {`BIT_CNT_W{1'b0}}) begin
                    flag_ff <= sda_s;
                end else begin
                    shift_ff <= {shift_ff[6:0], sda_s};
                end
                // The pin level is held for the whole byte, so the last bit's level is used.
                if (!three_wire_ff) begin
                    flag_ff <= dc_s;
                end
                if (bit_cnt_ff == last_bit) begin
                    bit_cnt_ff      <= {`BIT_CNT_W{1'b0}};
                    done_ff         <= 1'b1;
                    byte_ff         <= {shift_ff[6:0], sda_s};
                    byte_is_data_ff <= three_wire_ff ? flag_ff : dc_s;
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // Byte routing: command register, image planes or parameter stream.
    reg [7:0]             cmd_ff;
    reg [`RAM_ADDR_W-1:0] ram_addr_ff;
    reg                   ram_we_ff;
    reg                   ram_red_ff;
    reg [7:0]             ram_data_ff;
    wire                  cmd_is_read;
    wire                  cmd_is_ram;

    assign cmd_is_read = (cmd_ff == `RD_CMD_A) || (cmd_ff == `RD_CMD_B) ||
                         (cmd_ff == `RD_CMD_C) || (cmd_ff == `RD_CMD_D) ||
                         (cmd_ff == `RD_CMD_E) || (cmd_ff == `RD_CMD_F);
    assign cmd_is_ram  = (cmd_ff == `WR_RAM_BW_CMD) || (cmd_ff == `WR_RAM_RED_CMD);

    always @(posedge clk_i) begin
        if (core_rst) begin
            cmd_ff         <= `CMD_RESET_VAL;
            cmd_strobe_o   <= 1'b0;
            cmd_byte_o     <= `CMD_RESET_VAL;
            param_strobe_o <= 1'b0;
            param_byte_o   <= 8'h0_000;
            read_strobe_o  <= 1'b0;
            ram_addr_ff    <= `ADDR_RESET_VAL;
            ram_we_ff      <= 1'b0;
            ram_red_ff     <= 1'b0;
            ram_data_ff    <= 8'h0_000;
        end else begin
            cmd_strobe_o   <= 1'b0;
            param_strobe_o <= 1'b0;
            read_strobe_o  <= 1'b0;
            ram_we_ff      <= 1'b0;
            // The address counter steps after each stored byte and wraps at the plane end.
            if (ram_we_ff) begin
                ram_addr_ff <= (ram_addr_ff == `RAM_LAST_ADDR) ? `ADDR_RESET_VAL
                                                               : ram_addr_ff + 1'b1;
            end
            if (done_ff && !byte_is_data_ff) begin
                cmd_ff       <= byte_ff;
                cmd_strobe_o <= 1'b1;
                cmd_byte_o   <= byte_ff;
                ram_addr_ff  <= `ADDR_RESET_VAL;
                ram_red_ff   <= (byte_ff == `WR_RAM_RED_CMD);
            end else if (done_ff && cmd_is_read) begin
                read_strobe_o <= 1'b1;
            end else if (done_ff && cmd_is_ram) begin
                ram_we_ff   <= 1'b1;
                ram_data_ff <= byte_ff;
            end else if (done_ff) begin
                param_strobe_o <= 1'b1;
                param_byte_o   <= byte_ff;
            end
        end
    end

    image_ram u_image_ram (
        .clk_i       (clk_i),
        .we_i        (ram_we_ff),
        .plane_red_i (ram_red_ff),
        .waddr_i     (ram_addr_ff),
        .wdata_i     (ram_data_ff),
        .raddr_i     (disp_addr_i),
        .rdata_bw_o  (disp_bw_o),
        .rdata_red_o (disp_red_o)
    );

    // ======================================================================
    // Read-back driver. In 3-wire mode D7 appears on the falling edge after
    // the flag bit; in 4-wire mode D7 is ready before the first rising edge.
    // A 4-wire load waits for a low clock, so the trailing fall of the
    // previous byte cannot shift away the next byte's D7.
    reg [7:0] out_ff;
    reg       loaded_ff;
    wire      load_3w;
    wire      load_4w;

    assign load_3w = three_wire_ff && sclk_fall && bit_cnt_ff == 4'h0_001 && flag_ff;
    assign load_4w = !three_wire_ff && !cs_n_s && dc_s && !loaded_ff && !sclk_s &&
                     bit_cnt_ff == {`BIT_CNT_W{1'b0}};

    always @(posedge clk_i) begin
        if (core_rst) begin
            out_ff    <= 8'h0_000;
            loaded_ff <= 1'b0;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else if (cs_n_s || done_ff) begin
            loaded_ff <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else if (cmd_is_read && (load_3w || load_4w)) begin
            out_ff    <= {readback_data_i[6:0], 1'b0};
            sda_o     <= readback_data_i[7];
            sda_oe_o  <= 1'b1;
            loaded_ff <= 1'b1;
        end else if (loaded_ff && sclk_fall) begin
            sda_o  <= out_ff[7];
            out_ff <= {out_ff[6:0], 1'b0};
        end
    end

    // ======================================================================
    // Busy pin and cascade role. A slave keeps its analog blocks off and
    // takes its reference clock from the shared pin.
    reg div_ff;

    always @(posedge clk_i) begin
        if (core_rst) begin
            busy_o                 <= 1'b0;
            div_ff                 <= 1'b0;
            oscillator_en_o        <= 1'b0;
            booster_en_o           <= 1'b0;
            regulator_en_o         <= 1'b0;
            cascade_clock_pin_o    <= 1'b0;
            cascade_clock_pin_oe_o <= 1'b0;
            ref_clock_o            <= 1'b0;
        end else begin
            busy_o <= waveform_active_i | otp_program_active_i | temp_sensor_active_i;
            div_ff                 <= ~div_ff;
            oscillator_en_o        <= master_ff;
            booster_en_o           <= master_ff;
            regulator_en_o         <= master_ff;
            cascade_clock_pin_o    <= master_ff & div_ff;
            cascade_clock_pin_oe_o <= master_ff;
            ref_clock_o            <= master_ff ? div_ff : sync_ff[`SYNC_CASCADE_CLK];
        end
    end

endmodule // epd_host_serial_port

`default_nettype wire

// [sim/epd_host_serial_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epd_port_defines.vh"

// ==========================================================================
// Port checker for the host serial port.
module epd_host_serial_port_checker (
    // Clock and reset.
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Pins and straps.
    input wire logic       cs_n_i,
    input wire logic       reset_in_n_i,
    input wire logic       cascade_master_strap_i,
    input wire logic       waveform_active_i,
    input wire logic       otp_program_active_i,
    input wire logic       temp_sensor_active_i,
    // Outputs under watch.
    input wire logic       busy_o,
    input wire logic       cmd_strobe_o,
    input wire logic [7:0] cmd_byte_o,
    input wire logic       param_strobe_o,
    input wire logic       read_strobe_o,
    input wire logic       sda_oe_o,
    input wire logic       oscillator_en_o,
    input wire logic       booster_en_o,
    input wire logic       regulator_en_o,
    input wire logic       cascade_clock_pin_o,
    input wire logic       cascade_clock_pin_oe_o
);
    logic [2:0] live_ff;
    logic       ok;

    // Counts cycles out of both resets; the pin reset acts through synchronisers, so wait.
    always @(posedge clk_i) begin
        if (rst_i || !reset_in_n_i) begin
            live_ff <= 3'h0;
        end else if (live_ff != 3'h7) begin
            live_ff <= live_ff + 3'h1;
        end
    end
    assign ok = (live_ff == 3'h7);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_busy;
        ok && $past(ok) |-> busy_o == ($past(waveform_active_i) || $past(otp_program_active_i)
            || $past(temp_sensor_active_i));
    endproperty
    a_busy: assert property (p_busy) else $error("busy does not follow its sources");
    property p_cmd_pulse;
        cmd_strobe_o |-> !param_strobe_o ##1 !cmd_strobe_o;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe malformed");
    property p_cmd_hold;
        ok && $past(ok) && $changed(cmd_byte_o) |-> $past(cmd_strobe_o) or ##[0:1] cmd_strobe_o;
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command byte moved alone");
    property p_read_cmds;
        ok && read_strobe_o |-> cmd_byte_o inside {`RD_CMD_A, `RD_CMD_B, `RD_CMD_C,
            `RD_CMD_D, `RD_CMD_E, `RD_CMD_F};
    endproperty
    a_read_cmds: assert property (p_read_cmds) else $error("read under wrong command");
    property p_param_dest;
        ok && param_strobe_o |-> !(cmd_byte_o inside {`RD_CMD_A, `RD_CMD_B, `RD_CMD_C,
            `RD_CMD_D, `RD_CMD_E, `RD_CMD_F, `WR_RAM_BW_CMD, `WR_RAM_RED_CMD});
    endproperty
    a_param_dest: assert property (p_param_dest) else $error("data byte misrouted");
    property p_slave_off;
        ok |-> {oscillator_en_o, booster_en_o, regulator_en_o} == {3{cascade_master_strap_i}};
    endproperty
    a_slave_off: assert property (p_slave_off) else $error("analog enables wrong");
    property p_cl_drive;
        ok && $past(ok) |-> cascade_clock_pin_oe_o == cascade_master_strap_i
            && (!cascade_master_strap_i || cascade_clock_pin_o != $past(cascade_clock_pin_o));
    endproperty
    a_cl_drive: assert property (p_cl_drive) else $error("shared clock pin wrong");
    property p_sda_idle;
        cs_n_i [*5] |-> !sda_oe_o;
    endproperty
    a_sda_idle: assert property (p_sda_idle) else $error("data driven while deselected");
    property p_pin_reset;
        !reset_in_n_i [*5] |-> cmd_byte_o == `CMD_RESET_VAL && !busy_o && !sda_oe_o;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not honoured");
endmodule // epd_host_serial_port_checker

bind epd_host_serial_port epd_host_serial_port_checker checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .reset_in_n_i(reset_in_n_i),
    .cascade_master_strap_i(cascade_master_strap_i), .waveform_active_i(waveform_active_i),
    .otp_program_active_i(otp_program_active_i), .temp_sensor_active_i(temp_sensor_active_i),
    .busy_o(busy_o), .cmd_strobe_o(cmd_strobe_o), .cmd_byte_o(cmd_byte_o),
    .param_strobe_o(param_strobe_o), .read_strobe_o(read_strobe_o), .sda_oe_o(sda_oe_o),
    .oscillator_en_o(oscillator_en_o), .booster_en_o(booster_en_o),
    .regulator_en_o(regulator_en_o), .cascade_clock_pin_o(cascade_clock_pin_o),
    .cascade_clock_pin_oe_o(cascade_clock_pin_oe_o));
`default_nettype wire

// [sim/host_spi_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host microcontroller acting as serial master, 200 ns link clock.
module host_spi_model (
    // Resolved data line.
    input  wire logic sda_i,
    // Lines towards the device.
    output var logic  sclk_o,
    output var logic  sda_o,
    output var logic  cs_n_o,
    output var logic  dc_o
);
    // Idle: deselected, clock parked low between frames.
    initial begin
        sclk_o = 1'b0;
        sda_o = 1'b0;
        cs_n_o = 1'b1;
        dc_o = 1'b0;
    end

    task automatic cs(input logic v);
        cs_n_o = v;
        #100;
    endtask

    // One frame, or its first cnt bits; a released line toggles so stale bits never pass.
    task automatic frame(input logic three, flag, rd, input logic [7:0] b, input int cnt,
                         output logic [7:0] q);
        int n;
        n = three ? 9 : 8;
        if (cnt < n) n = cnt;
        dc_o = three ? 1'b0 : flag;
        for (int i = 0; i < n; i++) begin
            if (rd && i > 0) sda_o = ~sda_o;
            else sda_o = three ? (i == 0 ? flag : b[8-i]) : b[7-i];
            #100 sclk_o = 1'b1;
            q = {q[6:0], sda_i};
            #100 sclk_o = 1'b0;
        end
    endtask
endmodule // host_spi_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epd_port_defines.vh"

// ==========================================================================
// Self-checking bench for the host serial port.
module tb_top;
    logic        clk_i, rst_i, reset_in_n_i, mode_strap, master_strap, ext_cl;
    logic        wave_act, otp_act, temp_act;
    logic [7:0]  readback, q;
    logic [12:0] disp_addr;
    wire         sclk, host_sda, cs_n, dc, sda_o, sda_oe, cl_o, cl_oe, sda_w, cl_w;
    wire         busy, osc, boost, regen, ref_clk, cmd_stb, prm_stb, rd_stb;
    logic [7:0]  cmd_seen, prm_seen, rd_seen;
    wire  [7:0]  cmd_byte, prm_byte, bw, red;
    int          n_mismatch, checked, cyc;

    // Whoever enables its driver owns the wire.
    assign sda_w = sda_oe ? sda_o : host_sda;
    assign cl_w = cl_oe ? cl_o : ext_cl;

    epd_host_serial_port epd_host_serial_port_inst (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .cs_n_i(cs_n), .dc_i(dc), .reset_in_n_i(reset_in_n_i),
        .serial_mode_strap_i(mode_strap), .cascade_master_strap_i(master_strap),
        .cascade_clock_pin_i(cl_w), .cascade_clock_pin_o(cl_o), .cascade_clock_pin_oe_o(cl_oe),
        .ref_clock_o(ref_clk), .oscillator_en_o(osc), .booster_en_o(boost),
        .regulator_en_o(regen),
        .waveform_active_i(wave_act), .otp_program_active_i(otp_act),
        .temp_sensor_active_i(temp_act), .busy_o(busy), .cmd_strobe_o(cmd_stb),
        .cmd_byte_o(cmd_byte), .param_strobe_o(prm_stb), .param_byte_o(prm_byte),
        .readback_data_i(readback), .read_strobe_o(rd_stb), .disp_addr_i(disp_addr),
        .disp_bw_o(bw), .disp_red_o(red));

    host_spi_model host_spi_model_inst (
        .sda_i(sda_w), .sclk_o(sclk), .sda_o(host_sda), .cs_n_o(cs_n), .dc_o(dc));

    // Strobe counters, cleared by the bench reset; every strobe is a one-cycle pulse.
    always @(posedge clk_i) begin
        if (rst_i) begin
            {cmd_seen, prm_seen, rd_seen} <= 24'h0;
        end else begin
            cmd_seen <= cmd_seen + {7'h0, cmd_stb};
            prm_seen <= prm_seen + {7'h0, prm_stb};
            rd_seen  <= rd_seen + {7'h0, rd_stb};
        end
    end

    // 40 MHz system clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input string name, input logic [7:0] exp, got);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Straps only move under reset, since the port freezes them when reset ends.
    task automatic do_reset(input logic mode, master);
        rst_i = 1'b1;
        mode_strap = mode;
        master_strap = master;
        tick(12);
        rst_i = 1'b0;
        tick(6);
    endtask

    task automatic t_four;
        do_reset(1'b0, 1'b1);
        chk("analog_en", 8'h07, {5'h0, osc, boost, regen});
        host_spi_model_inst.cs(1'b0);
        host_spi_model_inst.frame(1'b0, 1'b0, 1'b0, 8'h5A, 9, q);
        host_spi_model_inst.frame(1'b0, 1'b1, 1'b0, 8'hC3, 9, q);
        host_spi_model_inst.cs(1'b1);
        tick(4);
        chk("cmd", 8'h5A, cmd_byte);
        chk("param", 8'hC3, prm_byte);
        host_spi_model_inst.cs(1'b0);
        host_spi_model_inst.frame(1'b0, 1'b0, 1'b0, 8'hFF, 3, q);
        host_spi_model_inst.cs(1'b1);
        host_spi_model_inst.cs(1'b0);
        host_spi_model_inst.frame(1'b0, 1'b0, 1'b0, `WR_RAM_BW_CMD, 9, q);
        host_spi_model_inst.frame(1'b0, 1'b1, 1'b0, 8'h96, 9, q);
        host_spi_model_inst.frame(1'b0, 1'b1, 1'b0, 8'h3C, 9, q);
        host_spi_model_inst.cs(1'b1);
        tick(4);
        chk("cmd_after_abort", `WR_RAM_BW_CMD, cmd_byte);
        disp_addr = 13'h0;
        tick(2);
        chk("bw0", 8'h96, bw);
        disp_addr = 13'h1;
        tick(2);
        chk("bw1", 8'h3C, bw);
        readback = 8'hA5;
        host_spi_model_inst.cs(1'b0);
        host_spi_model_inst.frame(1'b0, 1'b0, 1'b0, `RD_CMD_C, 9, q);
        host_spi_model_inst.frame(1'b0, 1'b1, 1'b1, 8'h00, 9, q);
        host_spi_model_inst.cs(1'b1);
        tick(4);
        chk("read_4w", 8'hA5, q);
        chk("cmd_strobes", 8'h03, cmd_seen);
        chk("param_strobes", 8'h01, prm_seen);
        chk("read_strobes", 8'h01, rd_seen);
        $display("t_four done");
    endtask

    task automatic t_busy;
        for (int i = 0; i < 3; i++) begin
            {wave_act, otp_act, temp_act} = 3'h4 >> i;
            tick(2);
            chk("busy_set", 8'h01, {7'h0, busy});
            {wave_act, otp_act, temp_act} = 3'h0;
            tick(2);
            chk("busy_clear", 8'h00, {7'h0, busy});
        end
        $display("t_busy done");
    endtask

    task automatic t_three;
        logic [7:0] rd_cmds [6];
        rd_cmds = '{`RD_CMD_A, `RD_CMD_B, `RD_CMD_C, `RD_CMD_D, `RD_CMD_E, `RD_CMD_F};
        do_reset(1'b1, 1'b0);
        chk("analog_en", 8'h00, {5'h0, osc, boost, regen});
        ext_cl = 1'b1;
        tick(4);
        chk("ref_clk_hi", 8'h01, {7'h0, ref_clk});
        ext_cl = 1'b0;
        tick(4);
        chk("ref_clk_lo", 8'h00, {7'h0, ref_clk});
        for (int i = 0; i < 6; i++) begin
            readback = ~rd_cmds[i];
            host_spi_model_inst.cs(1'b0);
            host_spi_model_inst.frame(1'b1, 1'b0, 1'b0, rd_cmds[i], 9, q);
            host_spi_model_inst.frame(1'b1, 1'b1, 1'b1, 8'h00, 9, q);
            host_spi_model_inst.cs(1'b1);
            tick(4);
            chk("read", ~rd_cmds[i], q);
            chk("cmd", rd_cmds[i], cmd_byte);
        end
        host_spi_model_inst.cs(1'b0);
        host_spi_model_inst.frame(1'b1, 1'b0, 1'b0, `WR_RAM_RED_CMD, 9, q);
        host_spi_model_inst.frame(1'b1, 1'b1, 1'b0, 8'h81, 9, q);
        host_spi_model_inst.frame(1'b1, 1'b0, 1'b0, 8'h10, 9, q);
        host_spi_model_inst.frame(1'b1, 1'b1, 1'b0, 8'h44, 9, q);
        host_spi_model_inst.cs(1'b1);
        tick(4);
        chk("param", 8'h44, prm_byte);
        disp_addr = 13'h0;
        tick(2);
        chk("red0", 8'h81, red);
        chk("cmd_strobes", 8'h08, cmd_seen);
        chk("param_strobes", 8'h01, prm_seen);
        chk("read_strobes", 8'h06, rd_seen);
        $display("t_three done");
    endtask

    task automatic t_reset_pin;
        reset_in_n_i = 1'b0;
        tick(6);
        chk("cmd_in_reset", `CMD_RESET_VAL, cmd_byte);
        reset_in_n_i = 1'b1;
        tick(8);
        $display("t_reset_pin done");
    endtask

    // Main sequence; busy sources stay low whenever the host sends.
    initial begin
        {rst_i, reset_in_n_i, mode_strap, master_strap} = 4'hD;
        {ext_cl, wave_act, otp_act, temp_act} = 4'h0;
        readback = 8'h00;
        disp_addr = 13'h0;
        n_mismatch = 0;
        checked = 0;
        cyc = 0;
        tick(1);
        t_four();
        t_busy();
        t_three();
        t_reset_pin();
        close_out();
    end

    // Hang guard, well above the roughly 1,800 cycles the tests need.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
endmodule // tb_top
`default_nettype wire
